/* verilog/nbs_regs.svh */
`ifndef NBS_REGS_SVH
`define NBS_REGS_SVH

// Double-rate clock period and timing counts in double-rate clocks
`define NBS_CLK_PERIOD_NS 20
`define NBS_PHASE_CLKS 2
`define NBS_ZERO_WAIT_CLKS 4
`define NBS_WDATA_SETUP_CLKS 3
`define NBS_WDATA_HOLD_CLKS 1

// Lane pattern forced onto the lower half in a second narrow cycle
`define NBS_LOW_HALF_OFF 2'h3
// Phase bit value held through reset so that release lands in phase 2
`define NBS_PHASE_AT_RESET 1'h1

`endif

/* verilog/nbs_pkg.sv */
`default_nettype none
package nbs_pkg;

    typedef enum logic [2:0] {
        NBS_IDLE = 3'b001,
        NBS_T1 = 3'b010,
        NBS_T2 = 3'b100
    } nbs_state_e;

    typedef struct packed {
        logic write;
        logic [31:2] addr;
        logic [3:0] lanes_n;
        logic [31:0] wdata;
    } nbs_req_s;

    typedef struct packed {
        logic low_byte_enable_n;
        logic high_byte_enable_n;
        logic word_address_bit;
    } nbs_narrow_s;

endpackage
`default_nettype wire

/* verilog/nbs_lane_convert.sv */
`timescale 1ns/1ps
`default_nettype none
module nbs_lane_convert (
    // Four active-low lane enables
    input wire logic [3:0] lane_enables_n_in,
    // 16-bit bus enables and word address bit
    output var nbs_pkg::nbs_narrow_s narrow_out
);
    import nbs_pkg::*;

    logic odd_word;

    // Odd word only when both low lanes are idle; empty or gapped
    // patterns never occur, so their result is left as it falls
    assign odd_word = lane_enables_n_in[1] & lane_enables_n_in[0];
    assign narrow_out.word_address_bit = odd_word;
    assign narrow_out.low_byte_enable_n = odd_word ?
        lane_enables_n_in[2] : lane_enables_n_in[0];
    assign narrow_out.high_byte_enable_n = odd_word ?
        lane_enables_n_in[3] : lane_enables_n_in[1];

endmodule
`default_nettype wire

/* verilog/nbs_bus_unit.sv */
// Function
// - Split both-half narrow transfer when no pipelined address is out; second drops low lanes
// - Ignore ready in first period, then sample
// - Zero-wait cycle spans four double-rate clocks
// - Pipelined address appears one period earlier
// - Each wait state adds one period
// - Write data driven three clocks before end
// - Write data held one clock past end
// - Reset release aligns phase, falls in phase 2
// - Narrow select and ready low together: narrow cycle
`timescale 1ns/1ps
`default_nettype none
`include "nbs_regs.svh"
module nbs_bus_unit (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Transfer request
    input wire logic req_valid_in,
    input wire nbs_pkg::nbs_req_s req_in,
    output logic req_ready_out,
    // Bus inputs
    input wire logic ready_n_in,
    input wire logic narrow_bus_select_n_in,
    input wire logic next_address_request_n_in,
    input wire logic [31:0] data_in,
    // Bus outputs
    output logic phase_clock_out,
    output logic address_strobe_n_out,
    output logic [31:2] addr_out,
    output logic [3:0] lane_enables_n_out,
    output logic write_out,
    output logic [31:0] data_out,
    output logic data_oe_out,
    // 16-bit bus enables
    output logic low_byte_enable_n_out,
    output logic high_byte_enable_n_out,
    output logic word_address_bit_out,
    // Completion
    output logic cycle_done_out,
    output logic [31:0] rdata_out
);
    import nbs_pkg::*;

    nbs_state_e st_q;
    nbs_narrow_s narrow;
    logic ph2_q;
    logic ads_n_q;
    logic [31:2] addr_q;
    logic [3:0] lanes_q;
    logic write_q;
    logic cur_write_q;
    logic [3:0] cur_lanes_q;
    logic [31:0] cur_wdata_q;
    logic second_q;
    logic pipe_q;
    logic oe_q;
    logic [31:0] wdata_out_q;
    logic done_q;
    logic [31:0] rdata_q;
    logic idle_take, pipe_ok, pipe_take, end_ok, both_halves, split;

    // Phase 1 when ph2_q is low; reset leaves it in phase 2
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ph2_q <= `NBS_PHASE_AT_RESET;
        end else begin
            ph2_q <= ~ph2_q;
        end
    end

    assign idle_take = (st_q == NBS_IDLE) && ph2_q && req_valid_in;
    // Ready looked at only on the last edge of a T2 period
    assign end_ok = (st_q == NBS_T2) && ph2_q && !ready_n_in;
    // Pipelining excluded for narrow, split and write cycles
    assign pipe_ok = (st_q == NBS_T2) && ph2_q && ready_n_in &&
        !next_address_request_n_in && narrow_bus_select_n_in &&
        !pipe_q && !second_q;
    assign pipe_take = pipe_ok && req_valid_in && !req_in.write;
    assign req_ready_out = ((st_q == NBS_IDLE) && ph2_q) ||
        (pipe_ok && !req_in.write);
    assign both_halves = !(&cur_lanes_q[1:0]) && !(&cur_lanes_q[3:2]);
    assign split = end_ok && !narrow_bus_select_n_in && both_halves &&
        !second_q && !pipe_q;

    // Cycle sequencing, one state per phase-clock period
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= NBS_IDLE;
        end else if (ph2_q) begin
            case (st_q)
                NBS_IDLE: begin
                    if (req_valid_in) begin
                        st_q <= NBS_T1;
                    end
                end
                NBS_T1: begin
                    st_q <= NBS_T2;
                end
                NBS_T2: begin
                    if (!ready_n_in) begin
                        if (split) begin
                            st_q <= NBS_T1;
                        end else if (pipe_q) begin
                            st_q <= NBS_T2;
                        end else begin
                            st_q <= NBS_IDLE;
                        end
                    end
                    // Not ready: one more T2 period
                end
                default: begin
                    st_q <= NBS_IDLE;
                end
            endcase
        end
    end

    // Address strobe for one period per issued address
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ads_n_q <= 1'b1;
        end else if (idle_take || split || pipe_take) begin
            ads_n_q <= 1'b0;
        end else if (ph2_q) begin
            ads_n_q <= 1'b1;
        end
    end

    // Address, lanes and direction on the bus
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            addr_q <= '0;
            lanes_q <= 4'hf;
            write_q <= 1'b0;
        end else if (idle_take || pipe_take) begin
            addr_q <= req_in.addr;
            lanes_q <= req_in.lanes_n;
            write_q <= req_in.write;
        end else if (split) begin
            // Address retained, low lanes forced off
            lanes_q <= {cur_lanes_q[3:2], `NBS_LOW_HALF_OFF};
        end
    end

    // Transfer currently owning the data bus
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cur_write_q <= 1'b0;
            cur_lanes_q <= 4'hf;
            cur_wdata_q <= '0;
            second_q <= 1'b0;
            pipe_q <= 1'b0;
        end else if (idle_take) begin
            cur_write_q <= req_in.write;
            cur_lanes_q <= req_in.lanes_n;
            cur_wdata_q <= req_in.wdata;
            second_q <= 1'b0;
        end else if (pipe_take) begin
            pipe_q <= 1'b1;
        end else if (split) begin
            cur_lanes_q <= {cur_lanes_q[3:2], `NBS_LOW_HALF_OFF};
            second_q <= 1'b1;
        end else if (end_ok && pipe_q) begin
            cur_write_q <= write_q;
            cur_lanes_q <= lanes_q;
            second_q <= 1'b0;
            pipe_q <= 1'b0;
        end
    end

    // Write data from the end of phase 1 of T1, held one clock past end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            oe_q <= 1'b0;
            wdata_out_q <= '0;
        end else if ((st_q == NBS_T1) && !ph2_q && cur_write_q) begin
            oe_q <= 1'b1;
            wdata_out_q <= (&cur_lanes_q[1:0]) ?
                {cur_wdata_q[31:16], cur_wdata_q[31:16]} : cur_wdata_q;
        end else if (done_q) begin
            oe_q <= 1'b0;
        end
    end

    // Read capture; narrow cycles steer the low half to its lanes
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_q <= '0;
        end else if (end_ok && !cur_write_q) begin
            if (!narrow_bus_select_n_in && (&cur_lanes_q[1:0])) begin
                rdata_q[31:16] <= data_in[15:0];
            end else if (!narrow_bus_select_n_in) begin
                rdata_q[15:0] <= data_in[15:0];
            end else begin
                rdata_q <= data_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            done_q <= 1'b0;
        end else begin
            done_q <= end_ok && !split;
        end
    end

    nbs_lane_convert u_conv (
        .lane_enables_n_in(lanes_q),
        .narrow_out(narrow)
    );

    assign phase_clock_out = ph2_q;
    assign address_strobe_n_out = ads_n_q;
    assign addr_out = addr_q;
    assign lane_enables_n_out = lanes_q;
    assign write_out = write_q;
    assign data_out = wdata_out_q;
    assign data_oe_out = oe_q;
    assign low_byte_enable_n_out = narrow.low_byte_enable_n;
    assign high_byte_enable_n_out = narrow.high_byte_enable_n;
    assign word_address_bit_out = narrow.word_address_bit;
    assign cycle_done_out = done_q;
    assign rdata_out = rdata_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    reset_phase_a: assert property ($past(reset_in) |-> ph2_q)
        else $error("phase not in phase 2 at reset release");
    phase_half_a: assert property (ph2_q |=> !ph2_q ##1 ph2_q)
        else $error("phase clock not half rate");
    ready_ignored_a: assert property (done_q |->
        $past(st_q == NBS_T2) && $past(ph2_q) && !$past(ready_n_in))
        else $error("cycle ended outside a T2 sample edge");
    zero_wait_a: assert property ((st_q == NBS_T1) && !ph2_q && !pipe_q
        ##3 (!ready_n_in && narrow_bus_select_n_in) |=> done_q)
        else $error("zero-wait cycle not four clocks");
    wait_state_a: assert property ((st_q == NBS_T2) && ph2_q &&
        ready_n_in |-> ##2 ((st_q == NBS_T2) && ph2_q))
        else $error("wait state not one period");
    wdata_setup_a: assert property (done_q && $past(cur_write_q) |->
        $past(oe_q, 1) && $past(oe_q, 2) && $past(oe_q, 3))
        else $error("write data not driven three clocks");
    wdata_hold_a: assert property (done_q && $past(cur_write_q) |->
        oe_q && $stable(wdata_out_q))
        else $error("write data not held past end");
    split_lanes_a: assert property (split |=> !ads_n_q &&
        lanes_q[1:0] == 2'h3 && $stable(addr_q) && st_q == NBS_T1)
        else $error("second narrow cycle lanes wrong");
    no_split_a: assert property (end_ok && !narrow_bus_select_n_in &&
        !both_halves |=> done_q)
        else $error("one-half narrow cycle split");
    pipe_early_a: assert property (pipe_take |=> !ads_n_q &&
        st_q == NBS_T2)
        else $error("pipelined address not issued early");
    conv_odd_a: assert property (word_address_bit_out ==
        (lanes_q[1] & lanes_q[0]))
        else $error("word address bit wrong");
    conv_enable_a: assert property (!(&lanes_q) |->
        !(low_byte_enable_n_out && high_byte_enable_n_out))
        else $error("no 16-bit byte enable active");

    write_done_c: cover property (done_q && $past(cur_write_q));
    split_c: cover property (split ##[1:40] done_q);
    wait_c: cover property ((st_q == NBS_T2) && ph2_q && ready_n_in);
    pipe_c: cover property (pipe_take ##[1:40] done_q);

endmodule
`default_nettype wire

/* testbench/nbs_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nbs_mem_model (
    // Clock and bus
    input wire logic clk_in,
    input wire logic phase_in,
    input wire logic strobe_n_in,
    input wire logic [31:2] addr_in,
    input wire logic [3:0] lanes_n_in,
    // Behaviour
    input wire logic [1:0] waits_in,
    input wire logic narrow_in,
    input wire logic early_in,
    // Replies
    output logic ready_n_out,
    output logic narrow_n_out,
    output logic [31:0] data_out
);
    logic busy_q = 1'b0;
    logic [1:0] cnt_q = 2'h0;
    logic fin;
    logic [31:0] word;
    assign fin = busy_q && cnt_q == 2'h0;
    assign word = {addr_in[17:2], 12'ha5a, lanes_n_in};
    // Early ready in the first state is legal and must be ignored
    assign ready_n_out = !(fin || (early_in && !strobe_n_in));
    assign narrow_n_out = !(narrow_in && fin);
    // Released lines show the inverse of the word
    assign data_out = fin ? word : ~word;
    // Cycle start seen at phase-2 ends on the fast clock
    always @(posedge clk_in) begin
        if (phase_in && !strobe_n_in) begin
            busy_q <= 1'b1;
            cnt_q <= waits_in;
        end else if (phase_in && busy_q) begin
            busy_q <= !fin;
            cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule
`default_nettype wire

/* testbench/tb_narrow_bus_sizing_clock_phase.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_narrow_bus_sizing_clock_phase;
    import nbs_pkg::*;
    localparam logic [31:0] WD = 32'h1357_9bdf;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic req_valid_in = 1'b0;
    nbs_req_s req_in = '0;
    logic next_address_request_n_in = 1'b1;
    logic [1:0] waits = 2'h0;
    logic narrow = 1'b0;
    logic early = 1'b1;
    logic req_ready_out, ready_n_in, narrow_bus_select_n_in, hold;
    logic phase_clock_out, address_strobe_n_out, write_out, data_oe_out;
    logic low_byte_enable_n_out, high_byte_enable_n_out;
    logic word_address_bit_out, cycle_done_out;
    logic [31:2] addr_out;
    logic [3:0] lane_enables_n_out, sec_ln;
    logic [31:0] data_in, data_out, rdata_out;
    logic [31:0] wexp = WD;
    logic [2:0] conv;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int n_a, n_e, n_o, t0;
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) cyc <= cyc + 1;
    nbs_bus_unit uut (.clk_in, .reset_in, .req_valid_in, .req_in,
        .req_ready_out, .ready_n_in, .narrow_bus_select_n_in,
        .next_address_request_n_in, .data_in, .phase_clock_out,
        .address_strobe_n_out, .addr_out, .lane_enables_n_out, .write_out,
        .data_out, .data_oe_out, .low_byte_enable_n_out,
        .high_byte_enable_n_out, .word_address_bit_out, .cycle_done_out,
        .rdata_out);
    nbs_mem_model mem (.clk_in, .phase_in(phase_clock_out),
        .strobe_n_in(address_strobe_n_out), .addr_in(addr_out),
        .lanes_n_in(lane_enables_n_out), .waits_in(waits),
        .narrow_in(narrow), .early_in(early), .ready_n_out(ready_n_in),
        .narrow_n_out(narrow_bus_select_n_in), .data_out(data_in));
    task automatic end_of_test();
        $display("Counts: %0d checks, %0d mismatches", check_count,
            miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // Expected {low, high, word bit} for each contiguous lane pattern; empty and gapped patterns fall to zero
    function automatic logic [2:0] cv(input logic [3:0] ln);
        case (ln)
            4'he: return 3'h2;
            4'hd, 4'h9, 4'h1: return 3'h4;
            4'hb: return 3'h3;
            4'h7: return 3'h5;
            4'h3: return 3'h1;
            default: return 3'h0;
        endcase
    endfunction
    task automatic take(input logic w, input logic [3:0] ln,
            input logic [31:2] a);
        int n;
        @(negedge clk_in);
        req_in = '{w, a, ln, WD};
        req_valid_in = 1'b1;
        #1;
        for (n = 0; n < 20 && req_ready_out !== 1'b1; n++) begin
            @(negedge clk_in);
            #1;
        end
        @(posedge clk_in);
        t0 = cyc;
        @(negedge clk_in);
        req_valid_in = 1'b0;
    endtask
    // Walks one transfer, noting strobe, sampling edge and data drive
    task automatic xfer(input logic w, input logic [3:0] ln,
            input logic [31:2] a);
        int n;
        take(w, ln, a);
        n_a = 0;
        n_e = 0;
        n_o = 0;
        sec_ln = 4'hf;
        for (n = 1; n < 60; n++) begin
            if (address_strobe_n_out === 1'b0 && n_a == 0) begin
                n_a = n;
                conv = {low_byte_enable_n_out, high_byte_enable_n_out,
                    word_address_bit_out};
                chk(write_out === w && addr_out === a, "addr");
            end else if (address_strobe_n_out === 1'b0 && n > n_a + 2)
                sec_ln = lane_enables_n_out;
            if (n == n_e + 1)
                hold = data_oe_out === 1'b1 && data_out === wexp;
            if (ready_n_in === 1'b0 && phase_clock_out === 1'b1 &&
                    address_strobe_n_out === 1'b1)
                n_e = n;
            if (data_oe_out === 1'b1 && n_o == 0)
                n_o = n;
            if (cycle_done_out === 1'b1)
                break;
            @(negedge clk_in);
        end
    endtask
    task automatic t_reset();
        logic [2:0] k;
        chk(phase_clock_out === 1'b1 && data_oe_out === 1'b0, "rst");
        reset_in = 1'b0;
        for (k = 3'h1; k < 3'h7; k++) begin
            @(negedge clk_in);
            chk(phase_clock_out === ~k[0], "phase clock");
        end
        $display("Test reset done");
    endtask
    task automatic t_basic();
        logic [31:2] a;
        int w;
        for (w = 0; w < 3; w++) begin
            waits = 2'(w);
            a = 30'h40 + 30'(w);
            xfer(1'b0, 4'h0, a);
            chk(n_e - n_a + 1 == 4 + 2 * w, "read length");
            chk(rdata_out === {a[17:2], 16'ha5a0}, "read data");
            xfer(1'b1, 4'h0, a);
            chk(n_e - n_o + 1 == 3 + 2 * w, "write setup");
            chk(hold === 1'b1, "write hold");
        end
        $display("Test basic done");
    endtask
    task automatic t_narrow();
        logic [3:0] pats [10] = '{4'he, 4'hd, 4'hc, 4'hb, 4'h9, 4'h8,
            4'h7, 4'h3, 4'h1, 4'h0};
        logic [3:0] ln;
        logic [15:0] lo;
        logic sp;
        int i;
        narrow = 1'b1;
        waits = 2'h0;
        early = 1'b0;
        for (i = 0; i < 10; i++) begin
            ln = pats[i];
            sp = ln[1:0] != 2'h3 && ln[3:2] != 2'h3;
            lo = {12'ha5a, ln};
            xfer(1'b0, ln, 30'(i));
            chk(conv === cv(ln), "converter");
            chk(sec_ln === (sp ? {ln[3:2], 2'h3} : 4'hf), "lanes");
            chk(n_e - n_a + 1 == (sp ? 8 : 4), "narrow length");
            chk(sp ? rdata_out === {lo[15:2], 2'h3, lo} : (&ln[1:0]) ?
                rdata_out[31:16] === lo : rdata_out[15:0] === lo,
                "rdata");
        end
        wexp = {WD[31:16], WD[31:16]};
        xfer(1'b1, 4'h3, 30'h9);
        chk(hold === 1'b1, "upper write copy");
        wexp = WD;
        narrow = 1'b0;
        $display("Test narrow done");
    endtask
    task automatic t_pipe();
        int t1;
        int i;
        waits = 2'h1;
        next_address_request_n_in = 1'b0;
        take(1'b0, 4'h0, 30'h100);
        t1 = t0;
        take(1'b0, 4'h0, 30'h104);
        chk(t0 - t1 == 4, "pipelined read");
        t1 = t0;
        take(1'b1, 4'h0, 30'h108);
        chk(t0 - t1 == 8, "write not pipelined");
        next_address_request_n_in = 1'b1;
        for (i = 0; i < 20 && cycle_done_out !== 1'b1; i++)
            @(negedge clk_in);
        $display("Test pipe done");
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        t_reset();
        t_basic();
        t_narrow();
        t_pipe();
        end_of_test();
    end
    initial begin
        #100000;
        miscompares++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
